// ---- sim/hardware_config_chk.sv ----
// Purpose: port assertions of the hardware config register
// Assumes: one clock domain, resetn asynchronous and active low
// Notes: bound to the design at the foot of this file
`timescale 1ns/100ps

module hardware_config_chk
   import hardware_config_pkg::*;
#(
   parameter int unsigned EE_TO_LONG_CYC = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Inputs watched
   input apb_req_s apb_req,
   input apb_rsp_s apb_rsp,
   input wire logic eeprom_present,
   input wire logic otp_configured,
   input wire logic phy_link_pin,
   input wire logic gpio_wake_pin,
   input wire logic ee_start,
   // Outputs watched
   input wire logic eeprom_timeout_flag,
   input wire logic internal_gig_clock_enable,
   input wire logic ref_clock_out_enable,
   input wire logic usb_attach,
   input wire logic descriptor_from_ram,
   input wire logic multi_frame_packing
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Completed transfers
   sequence s_done;
      apb_req.psel && apb_req.penable && apb_rsp.pready;
   endsequence
   sequence s_wr;
      s_done ##0 apb_req.pwrite && apb_req.paddr == HARDWARE_CONFIG_OFFSET;
   endsequence
   sequence s_rd;
      s_done ##0 !apb_req.pwrite && apb_req.paddr == HARDWARE_CONFIG_OFFSET;
   endsequence

   // ==========================================================
   // Properties
   rsv_zero_a: assert property (
      s_rd |-> (apb_rsp.prdata & 32'hFCFF0F04) == 32'h00000000)
      else $error("reserved bits read nonzero");
   gig_follow_a: assert property (
      s_wr |-> ##2 internal_gig_clock_enable == $past(apb_req.pwdata[25], 2))
      else $error("internal clock enable not written value");
   ref_follow_a: assert property (
      s_wr |-> ##2 ref_clock_out_enable == $past(apb_req.pwdata[24], 2))
      else $error("reference clock enable not written value");
   pack_follow_a: assert property (
      s_wr |-> ##2 multi_frame_packing == $past(apb_req.pwdata[4], 2))
      else $error("packing output not written value");
   detach_go_a: assert property (
      s_wr ##0 apb_req.pwdata[DET_EN_BIT] |=> !usb_attach)
      else $error("no detach after enable write");
   stay_off_a: assert property (
      $rose(usb_attach) |-> $past(phy_link_pin, 2) || $past(gpio_wake_pin, 2))
      else $error("reattach without a pin cause");
   desc_gate_a: assert property (
      eeprom_present || otp_configured |=> !descriptor_from_ram)
      else $error("descriptor source used with image present");
   to_min_a: assert property (
      ee_start |=> !eeprom_timeout_flag [*8])
      else $error("eeprom time-out too early");
   flag_pulse_a: assert property (
      eeprom_timeout_flag |=> !eeprom_timeout_flag)
      else $error("time-out flag longer than one cycle");
   unmapped_err_a: assert property (
      s_done ##0 apb_req.paddr != HARDWARE_CONFIG_OFFSET |-> apb_rsp.pslverr)
      else $error("unmapped access without error");
endmodule

bind hardware_config_register hardware_config_chk #(
   .EE_TO_LONG_CYC(EE_TO_LONG_CYC)
) u_hardware_config_chk (.clk, .resetn, .apb_req, .apb_rsp, .eeprom_present,
   .otp_configured, .phy_link_pin, .gpio_wake_pin, .ee_start,
   .eeprom_timeout_flag, .internal_gig_clock_enable, .ref_clock_out_enable,
   .usb_attach, .descriptor_from_ram, .multi_frame_packing);

// ---- sim/link_partner.sv ----
// Purpose: cable and wake source that brings a detached device back
// Assumes: pins are levels, rising edge of clk used only for timing
// Notes: alternates phy link and wake pin on each detach
`timescale 1ns/100ps

module link_partner (
   // Clock and device state
   input wire logic clk,
   input wire logic usb_attach,
   // Reattach pins
   output logic phy_link_pin,
   output logic gpio_wake_pin
);
   int cnt = 0;
   logic use_gpio = 1'b0;

   // ==========================================================
   // Pin raised a while after detach, dropped again once attached
   always @(posedge clk) begin
      if (!usb_attach) begin
         cnt <= cnt + 1;
         if (cnt == 20) begin
            phy_link_pin <= !use_gpio;
            gpio_wake_pin <= use_gpio;
         end
      end else begin
         if (cnt != 0) begin
            use_gpio <= !use_gpio;
         end
         cnt <= 0;
         phy_link_pin <= 1'b0;
         gpio_wake_pin <= 1'b0;
      end
   end
endmodule

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the hardware config register
// Assumes: 10 MHz clock, ce dropped once, EEPROM image after first power-on, OTP image after the second
// Notes: long EEPROM time-out shortened to 50 cycles
`timescale 1ns/100ps

module tb;
   import hardware_config_pkg::*;
   localparam int LONG_CYC = 50;
   localparam int SHORT_CYC = (1280 + 99) / 100;
   localparam logic [31:0] RW_MASK = 32'h030030F8;
   logic clk = 1'b0;
   logic ce = 1'b1;
   logic resetn = 1'b0;
   logic usb_reset = 1'b0;
   logic lite_soft_reset = 1'b0;
   logic eeprom_present = 1'b1;
   logic otp_configured = 1'b0;
   logic ee_start = 1'b0;
   logic ee_done = 1'b0;
   pwr_e power_state = PWR_ACTIVE;
   cfg_s eeprom_image, otp_image;
   apb_req_s apb_req;
   apb_rsp_s apb_rsp;
   logic phy_link_pin, gpio_wake_pin, eeprom_timeout_flag, suspend_pin;
   logic internal_gig_clock_enable, ref_clock_out_enable, usb_attach;
   logic descriptor_from_ram, multi_frame_packing, err;
   logic [31:0] rd, w;
   int seed = 32'hD2AD;
   int n_fail = 0;
   int n_compared = 0;
   int n;

   // ==========================================================
   // Design and far side
   hardware_config_register #(.EE_TO_LONG_CYC(LONG_CYC))
      u_hardware_config_register (.clk, .resetn, .ce, .apb_req,
      .apb_rsp, .usb_reset, .lite_soft_reset, .eeprom_present,
      .otp_configured, .eeprom_image, .otp_image, .phy_link_pin,
      .gpio_wake_pin, .power_state, .ee_start, .ee_done,
      .eeprom_timeout_flag, .internal_gig_clock_enable,
      .ref_clock_out_enable, .usb_attach, .descriptor_from_ram,
      .multi_frame_packing, .suspend_pin);
   link_partner u_link_partner (.clk, .usb_attach, .phy_link_pin,
      .gpio_wake_pin);

   always #50 clk = ~clk;

   // ==========================================================
   // Expectations
   function automatic logic [31:0] img(input cfg_s c);
      return {6'h00, c.gig_clk, c.ref_clk, 10'h000, c.desc_sel, c.protect,
         4'h0, c.susp_sel, c.susp_pol, 5'h00};
   endfunction
   function automatic logic susp_exp(input logic [1:0] md, input logic pl,
                                     input pwr_e st, input logic dt);
      logic h;
      h = st == PWR_S2 || (md != 2'h0 && (st == PWR_S1 || dt))
         || (md[1] && st == PWR_S0) || (md == 2'h3 && st == PWR_S3);
      return pl ? h : !h;
   endfunction

   // ==========================================================
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // One APB transfer; ready is taken at the edge that samples it
   task automatic apb(input logic [11:0] a, input logic wr,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr,
         pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         test_done();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [31:0] exp);
      apb(HARDWARE_CONFIG_OFFSET, 1'b0, 32'h00000000);
      chk(nm, exp, rd);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      apb_req = '0;
      eeprom_image = 7'($random(seed));
      otp_image = 7'($random(seed));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("image", img(eeprom_image));
      $display("test reset done");
      // Random words, reserved bits must drop out
      for (int k = 0; k < 8; k++) begin
         w = $random(seed) & ~32'h00004000;
         w[13] = w[13] | (k == 0);
         @(posedge clk);
         eeprom_present <= (k != 0) & 1'($random(seed));
         otp_configured <= (k > 1) & 1'($random(seed));
         apb(HARDWARE_CONFIG_OFFSET, 1'b1, w);
         rchk("rw", w & RW_MASK);
         chk("gig", w[25], internal_gig_clock_enable);
         chk("ref", w[24], ref_clock_out_enable);
         chk("pack", w[4], multi_frame_packing);
         chk("desc", w[13] & !eeprom_present & !otp_configured,
            descriptor_from_ram);
      end
      apb(12'h014, 1'b1, 32'hFFFFFFFF);
      chk("wr_err", 1'b1, err);
      rchk("kept", w & RW_MASK);
      $display("test random done");
      // Soft resets, unprotected then protected
      @(posedge clk);
      eeprom_present <= 1'b1;
      apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'h030020F8);
      repeat (2) @(posedge clk);
      usb_reset <= 1'b1;
      @(posedge clk);
      usb_reset <= 1'b0;
      rchk("usb_rst", img(eeprom_image));
      apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'h030030F8);
      repeat (2) @(posedge clk);
      lite_soft_reset <= 1'b1;
      @(posedge clk);
      lite_soft_reset <= 1'b0;
      rchk("lite_rst", 32'h030030E0);
      $display("test soft_reset done");
      // Power-on reset ignores protection; OTP image with no EEPROM
      @(posedge clk);
      eeprom_present <= 1'b0;
      otp_configured <= 1'b1;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("por", img(otp_image));
      // A soft reset pulse while the clock enable is low is lost
      apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'h00000010);
      @(posedge clk);
      ce <= 1'b0;
      usb_reset <= 1'b1;
      @(posedge clk);
      ce <= 1'b1;
      usb_reset <= 1'b0;
      rchk("frozen", 32'h00000010);
      $display("test power_on done");
      // Every mode and polarity against every power state
      for (int m = 0; m < 8; m++) begin
         apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'(m) << 5);
         for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            power_state <= pwr_e'(s);
            repeat (2) @(posedge clk);
            chk("susp", susp_exp(m[2:1], m[0], pwr_e'(s), 1'b0),
               suspend_pin);
         end
      end
      @(posedge clk);
      power_state <= PWR_ACTIVE;
      $display("test suspend done");
      // Detach twice: reattach by link, then by wake pin
      for (int r = 0; r < 2; r++) begin
         apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'h00004060);
         rchk("det_on", 32'h00004060);
         chk("attach", 1'b0, usb_attach);
         chk("susp_det", 1'b1, suspend_pin);
         for (n = 0; n < 100 && usb_attach !== 1'b1; n++) begin
            @(posedge clk);
         end
         chk("reattach", 1'b1, usb_attach);
         if (n == 100) begin
            test_done();
         end
         rchk("sts", 32'h00008060);
         apb(HARDWARE_CONFIG_OFFSET, 1'b1, 32'h00008060);
         rchk("clr", 32'h00000060);
      end
      $display("test detach done");
      // Short, long and answered EEPROM accesses
      for (int t = 0; t < 3; t++) begin
         apb(HARDWARE_CONFIG_OFFSET, 1'b1, (t == 0) ? 32'h00000008 : 32'h00000000);
         @(posedge clk);
         ee_start <= 1'b1;
         @(posedge clk);
         ee_start <= 1'b0;
         ee_done <= (t == 2);
         @(posedge clk);
         ee_done <= 1'b0;
         for (n = 1; n < 100; n++) begin
            #1;
            if (eeprom_timeout_flag === 1'b1) break;
            @(posedge clk);
         end
         chk("to_len", (t == 0) ? SHORT_CYC : (t == 1) ? LONG_CYC : 100,
            n);
      end
      $display("test timeout done");
      test_done();
   end
endmodule

// ---- verilog/ee_timeout.sv ----
// Purpose: no-response watchdog for EEPROM accesses
// Assumes: start and done are one-cycle pulses on clk
// Notes: the length is chosen at start and held for the access
`timescale 1ns/100ps

module ee_timeout #(
   parameter int unsigned LONG_CYC = 300000,
   parameter int unsigned SHORT_CYC = 13,
   parameter int CNT_W = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Access tracking
   input wire logic start,
   input wire logic done,
   input wire logic short_sel,
   output logic timeout
);

   logic busy_r, busy_nxt;
   logic to_r, to_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   // ==========================================================
   // Load the limit at start, count down, flag on reaching one
   always_comb begin
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      to_nxt = 1'b0;
      if (start) begin
         busy_nxt = 1'b1;
         cnt_nxt = short_sel ? CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);
      end else if (busy_r && done) begin
         busy_nxt = 1'b0;
      end else if (busy_r) begin
         if (cnt_r <= CNT_W'(1)) begin
            busy_nxt = 1'b0;
            to_nxt = 1'b1;
         end
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         to_r <= 1'b0;
      end else if (ce) begin
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         to_r <= to_nxt;
      end
   end

   assign timeout = to_r;

endmodule

// ---- verilog/hardware_config_pkg.sv ----
// Purpose: constants, types and helpers of the hardware config register
// Assumes: 10 MHz core clock, APB with 32-bit data
// Notes: every field position and time-out count is named here, and the reset values of all fields but the detach enable
package hardware_config_pkg;

   // ==========================================================
   // Register map
   localparam int ADDR_W = 12;
   localparam logic [11:0] HARDWARE_CONFIG_OFFSET = 12'h010;
   localparam int GIG_CLK_BIT = 25;
   localparam int REF_CLK_BIT = 24;
   localparam int DET_STS_BIT = 15;
   localparam int DET_EN_BIT = 14;
   localparam int DESC_SEL_BIT = 13;
   localparam int PROTECT_BIT = 12;
   localparam int SUSP_SEL_LSB = 6;
   localparam int SUSP_POL_BIT = 5;
   localparam int PACK_BIT = 4;
   localparam int TO_SEL_BIT = 3;

   // ==========================================================
   // Reset values of fields not taken from the image
   localparam logic PACK_RST = 1'h0;
   localparam logic TO_SEL_RST = 1'h0;
   localparam logic DET_STS_RST = 1'h0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int EE_TO_LONG_MS = 30;
   localparam int EE_TO_SHORT_NS = 1280; // 1.28 us
   localparam int EE_TO_LONG_CYC_DEF = EE_TO_LONG_MS * 1000000
      / CLK_PERIOD_NS;
   localparam int EE_TO_SHORT_CYC = (EE_TO_SHORT_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   // Image-loaded fields, all of them reset-protected
   typedef struct packed {
      logic gig_clk;
      logic ref_clk;
      logic desc_sel;
      logic protect;
      logic [1:0] susp_sel;
      logic susp_pol;
   } cfg_s;

   localparam cfg_s CFG_RST = '0;

   typedef enum logic [2:0] {
      PWR_ACTIVE, PWR_S0, PWR_S1, PWR_S2, PWR_S3
   } pwr_e;

   // ==========================================================
   // Helpers
   // Image source priority: EEPROM, then programmed OTP, then zero
   function automatic cfg_s image_pick(input logic ee, input logic otp,
                                       input cfg_s ee_img,
                                       input cfg_s otp_img);
      if (ee) begin
         return ee_img;
      end else if (otp) begin
         return otp_img;
      end
      return CFG_RST;
   endfunction

   // Whether the suspend pin is asserted for this mode and state
   function automatic logic suspend_hit(input logic [1:0] sel,
                                        input pwr_e st,
                                        input logic det);
      logic hit;
      hit = (st == PWR_S2);
      if (sel != 2'h0) begin
         hit = hit | (st == PWR_S1) | det;
      end
      if (sel[1]) begin
         hit = hit | (st == PWR_S0);
      end
      if (sel == 2'h3) begin
         hit = hit | (st == PWR_S3);
      end
      return hit;
   endfunction

endpackage

// ---- verilog/hardware_config_register.sv ----
// Purpose: hardware configuration register with link-driven detach
// Assumes: APB slave on the core clock; resets other than power-on
//   arrive as one-cycle pulses on the same clock
// Notes: power-on reset is resetn; it loads the image one cycle after
//   release, the asynchronous branch only takes constants
`timescale 1ns/100ps

module hardware_config_register
   import hardware_config_pkg::*;
#(
   parameter int unsigned EE_TO_LONG_CYC = EE_TO_LONG_CYC_DEF
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Register bus
   input apb_req_s apb_req,
   output apb_rsp_s apb_rsp,
   // Resets other than power-on
   input wire logic usb_reset,
   input wire logic lite_soft_reset,
   // Configuration image
   input wire logic eeprom_present,
   input wire logic otp_configured,
   input cfg_s eeprom_image,
   input cfg_s otp_image,
   // Reattach pins
   input wire logic phy_link_pin,
   input wire logic gpio_wake_pin,
   // Power state of the device
   input pwr_e power_state,
   // EEPROM controller
   input wire logic ee_start,
   input wire logic ee_done,
   output logic eeprom_timeout_flag,
   // Controls to the rest of the device
   output logic internal_gig_clock_enable,
   output logic ref_clock_out_enable,
   output logic usb_attach,
   output logic descriptor_from_ram,
   output logic multi_frame_packing,
   output logic suspend_pin
);

   // ==========================================================
   // Declarations
   // Detach state: on the bus, or waiting for a reattach cause
   typedef enum logic {
      LINKED, DETACHED
   } det_e;

   det_e det_r, det_nxt;
   cfg_s cfg_r, cfg_nxt;
   logic pack_r, pack_nxt;
   logic to_sel_r, to_sel_nxt;
   logic sts_r, sts_nxt;
   logic init_r, init_nxt;
   logic reattach;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic attach_r, attach_nxt;
   logic desc_ram_r, desc_ram_nxt;
   logic susp_r, susp_nxt;
   logic [1:0] pins_s;
   logic soft_rst;
   logic hit;
   logic wr;
   logic [31:0] wd;
   cfg_s image;

   // ==========================================================
   // Pin synchronisers for link and wake
   // Both pins come from outside the clock domain
   pin_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .din({phy_link_pin, gpio_wake_pin}),
      .dout(pins_s)
   );

   // ==========================================================
   // EEPROM no-response watchdog
   // Its length follows the time-out select at each start
   ee_timeout #(
      .LONG_CYC(EE_TO_LONG_CYC),
      .SHORT_CYC(EE_TO_SHORT_CYC),
      .CNT_W(20)
   ) u_timeout (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .start(ee_start),
      .done(ee_done),
      .short_sel(to_sel_r),
      .timeout(eeprom_timeout_flag)
   );

   // ==========================================================
   // Bus decode
   // Write lands at the completing edge of the access phase only
   // Only word address bits are decoded; byte offsets are ignored
   assign hit = (apb_req.paddr[ADDR_W-1:2] == HARDWARE_CONFIG_OFFSET[ADDR_W-1:2]);
   assign wr = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite
      & hit;
   assign wd = apb_req.pwdata;
   assign soft_rst = usb_reset | lite_soft_reset;
   assign image = image_pick(eeprom_present, otp_configured,
                             eeprom_image, otp_image);

   // ==========================================================
   // Bus answer: one wait state so the answer comes from flops
   // First access cycle: ready, error and read data are registered
   // Second access cycle: the master sees ready and completes
   // Read data stay put until the next access answers, so a slow
   // master may pick them up late without harm
   // An unmapped address answers with an error and zero data
   always_comb begin
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      if (apb_req.psel && apb_req.penable && !pready_r) begin
         pready_nxt = 1'b1;
         pslverr_nxt = !hit;
         prdata_nxt = 32'h0000_0000;
         if (hit && !apb_req.pwrite) begin
            prdata_nxt[GIG_CLK_BIT] = cfg_r.gig_clk;
            prdata_nxt[REF_CLK_BIT] = cfg_r.ref_clk;
            prdata_nxt[DET_STS_BIT] = sts_r;
            prdata_nxt[DET_EN_BIT] = (det_r == DETACHED);
            prdata_nxt[DESC_SEL_BIT] = cfg_r.desc_sel;
            prdata_nxt[PROTECT_BIT] = cfg_r.protect;
            prdata_nxt[SUSP_SEL_LSB+1] = cfg_r.susp_sel[1];
            prdata_nxt[SUSP_SEL_LSB] = cfg_r.susp_sel[0];
            prdata_nxt[SUSP_POL_BIT] = cfg_r.susp_pol;
            prdata_nxt[PACK_BIT] = pack_r;
            prdata_nxt[TO_SEL_BIT] = to_sel_r;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (ce) begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ==========================================================
   // Detach sequencer
   // Leaves USB on a write of one to the enable, returns on link
   // or wake; a cable still plugged gives a quick reattach
   // Pins are only looked at while detached, so a link that stays
   // up after reattach cannot cause a second event
   // A detach write while already detached is ignored; the state
   // only leaves LINKED on that write
   always_comb begin
      det_nxt = det_r;
      reattach = 1'b0;
      case (det_r)
         LINKED: begin
            if (wr && wd[DET_EN_BIT]) begin
               det_nxt = DETACHED;
            end
         end
         DETACHED: begin
            if (pins_s[1] || pins_s[0]) begin
               det_nxt = LINKED;
               reattach = 1'b1;
            end
         end
         default: begin
            det_nxt = LINKED;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         det_r <= LINKED;
      end else if (ce) begin
         det_r <= det_nxt;
      end
   end

   // ==========================================================
   // Configuration fields
   // Soft resets reload from the image unless protection is on;
   // every image field is a protected one, so it moves as a whole
   // Power-on reset cannot load the image in its asynchronous
   // branch, so init_r asks for the load one edge after release
   // Packing and time-out select are not image fields: every reset
   // returns them to zero whatever the protection bit says
   // A configuration write in a soft reset cycle is lost; the
   // reset has priority so software sees a known state afterwards
   always_comb begin
      cfg_nxt = cfg_r;
      pack_nxt = pack_r;
      to_sel_nxt = to_sel_r;
      init_nxt = 1'b0;
      // Status: a reattach in the clearing cycle wins
      sts_nxt = sts_r;
      if (wr && wd[DET_STS_BIT]) begin
         sts_nxt = 1'b0;
      end
      if (reattach) begin
         sts_nxt = 1'b1;
      end
      if (init_r) begin
         cfg_nxt = image;
         pack_nxt = PACK_RST;
         to_sel_nxt = TO_SEL_RST;
      end else if (soft_rst) begin
         if (!cfg_r.protect) begin
            cfg_nxt = image;
         end
         pack_nxt = PACK_RST;
         to_sel_nxt = TO_SEL_RST;
      end else if (wr) begin
         cfg_nxt.gig_clk = wd[GIG_CLK_BIT];
         cfg_nxt.ref_clk = wd[REF_CLK_BIT];
         cfg_nxt.desc_sel = wd[DESC_SEL_BIT];
         cfg_nxt.protect = wd[PROTECT_BIT];
         cfg_nxt.susp_sel = wd[SUSP_SEL_LSB+1 -: 2];
         cfg_nxt.susp_pol = wd[SUSP_POL_BIT];
         pack_nxt = wd[PACK_BIT];
         to_sel_nxt = wd[TO_SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_r <= CFG_RST;
         pack_r <= PACK_RST;
         to_sel_r <= TO_SEL_RST;
         sts_r <= DET_STS_RST;
         init_r <= 1'b1;
      end else if (ce) begin
         cfg_r <= cfg_nxt;
         pack_r <= pack_nxt;
         to_sel_r <= to_sel_nxt;
         sts_r <= sts_nxt;
         init_r <= init_nxt;
      end
   end

   // ==========================================================
   // Registered controls to the rest of the device
   // The attach output uses the next state so it moves on the same
   // edge as the state itself
   // The suspend pin lags a power state change by one edge; its
   // reset level is the inactive level of an active-low pin
   always_comb begin
      attach_nxt = (det_nxt == LINKED);
      // Ignored whenever an EEPROM or configured OTP supplies data
      desc_ram_nxt = cfg_nxt.desc_sel & !eeprom_present
         & !otp_configured;
      // Pin follows mode and polarity, never the descriptor source
      susp_nxt = suspend_hit(cfg_r.susp_sel, power_state,
                             det_r == DETACHED);
      if (!cfg_r.susp_pol) begin
         susp_nxt = !susp_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         attach_r <= 1'b1;
         desc_ram_r <= 1'b0;
         susp_r <= 1'b1;
      end else if (ce) begin
         attach_r <= attach_nxt;
         desc_ram_r <= desc_ram_nxt;
         susp_r <= susp_nxt;
      end
   end

   // ==========================================================
   // Output mapping, each straight from a flop
   // Clock enables gate the clock generators; the 10 MHz core
   // cannot make those clocks itself
   assign internal_gig_clock_enable = cfg_r.gig_clk;
   assign ref_clock_out_enable = cfg_r.ref_clk;
   assign multi_frame_packing = pack_r;
   assign usb_attach = attach_r;
   assign descriptor_from_ram = desc_ram_r;
   assign suspend_pin = susp_r;
   // Bus answer signals leave straight from their flops
   assign apb_rsp.prdata = prdata_r;
   assign apb_rsp.pready = pready_r;
   assign apb_rsp.pslverr = pslverr_r;

endmodule

// ---- verilog/pin_sync.sv ----
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps

module pin_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_r, s2_r, s3_r, out_r;
   logic [W-1:0] out_nxt;

   // ==========================================================
   // Filter: a change counts once two later stages agree
   always_comb begin
      out_nxt = out_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            out_nxt[i] = s3_r[i];
         end
      end
   end

   // Stage one feeds only stage two
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else if (ce) begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign dout = out_r;

endmodule
